/* shared/ppc_pkg.sv */
// register map, reset values and field layout of the port pin block
`default_nettype none
package ppc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORT_W = 8;
  // register addresses
  localparam logic [15:0] ADDR_PORT1_DATA = 16'hff01;
  localparam logic [15:0] ADDR_PORT2_DATA = 16'hff02;
  localparam logic [15:0] ADDR_PORT3_DATA = 16'hff03;
  localparam logic [15:0] ADDR_PORT1_DIR = 16'hff21;
  localparam logic [15:0] ADDR_PORT3_DIR = 16'hff23;
  localparam logic [15:0] ADDR_PORT1_FSEL = 16'hff41;
  localparam logic [15:0] ADDR_PORT3_FSEL = 16'hff43;
  localparam logic [15:0] ADDR_PULLUP_OPTION_LOW = 16'hff4e;
  localparam logic [15:0] ADDR_PORT3_OPEN_DRAIN = 16'hff80;
  localparam logic [15:0] ADDR_EXT_INT_EDGE_CFG0 = 16'hff8c;
  localparam logic [15:0] ADDR_EXT_INT_EDGE_CFG1 = 16'hff8d;
  // reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_FSEL = 8'h00;
  localparam logic [7:0] RST_PULLUP_OPTION_LOW = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_EDGE_CFG = 8'h00;
  // implemented bits
  localparam logic [7:0] PORT1_FSEL_MASK = 8'h1c;
  localparam logic [7:0] PULLUP_OPTION_MASK = 8'h7f;
  localparam logic [7:0] OPEN_DRAIN_MASK = 8'h0c;
  localparam logic [7:0] PORT2_PULLUP_LINES = 8'hfc;
  // field positions
  localparam int unsigned PU_PORT1_BIT = 1;
  localparam int unsigned PU_PORT2_BIT = 2;
  localparam int unsigned PU_PORT3_BIT = 3;
  localparam int unsigned NMI_EDGE_BIT = 0;
  localparam int unsigned NUM_EXT_INT = 6;
  // edge selection codes of a two-bit field
  typedef enum logic [1:0] {
    ppc_edge_fall = 2'h0,
    ppc_edge_rise = 2'h1,
    ppc_edge_both = 2'h2,
    ppc_edge_none = 2'h3
  } ppc_edge_t;
endpackage : ppc_pkg
`default_nettype wire

/* core/ppc_ports.sv */
// pin logic of the first three ports: readback, direction, alternate functions, pull-ups
//
// Contract
// - port1 control out, dir 1: read pin
// - port1 control out, dir 0: read internal signal
// - port1 control input, dir 1: read pin
// - port1 pull-up on input pins when enabled
// - pull-up also applies to control outputs
// - pull-up option register, bit7 zero, reset 00
// - port2 input only, always readable
// - port2 pins always feed peripheral inputs
// - port2 group pull-up, upper six lines only
// - nmi accepted regardless of interrupt enable
// - nmi edge chosen by edge config zero
// - six external interrupts on selected edge
// - interrupt lines also feed timers and triggers
// - port3 reset: all inputs, outputs off
// - port3 per-bit port or control mode
// - port3 pin levels always readable; code reads the pin on direction-1 bits only
// - port3 serial0 lines support open drain
// - port3 port mode direction from register
// - port3 pull-up on direction-1 pins
// - port1 bits 2-4 route serial2 signals
// - port1 reset: all inputs, outputs off
`default_nettype none
module ppc_ports
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // first port pins
  input wire logic [PORT_W-1:0] port1_pin_in,
  output logic [PORT_W-1:0] port1_pin_out,
  output logic [PORT_W-1:0] port1_pin_oe,
  output logic [PORT_W-1:0] port1_pullup_on,
  // second port pins
  input wire logic [PORT_W-1:0] port2_pin_in,
  output logic [PORT_W-1:0] port2_pullup_on,
  // third port pins
  input wire logic [PORT_W-1:0] port3_pin_in,
  output logic [PORT_W-1:0] port3_pin_out,
  output logic [PORT_W-1:0] port3_pin_oe,
  output logic [PORT_W-1:0] port3_pullup_on,
  // serial 2 peripheral on the first port
  input wire logic serial2_clock_out,
  input wire logic serial2_clock_drive,
  input wire logic serial2_data_out,
  output logic serial2_clock_in,
  output logic serial2_data_in,
  // peripherals on the third port
  input wire logic serial1_data_out,
  input wire logic serial0_clock,
  input wire logic serial0_clock_drive,
  input wire logic serial0_data_out,
  input wire logic [3:0] timer_out,
  output logic serial1_data_in,
  output logic serial0_clock_in,
  // interrupt requests from the second port
  output logic nmi_request,
  output logic [NUM_EXT_INT-1:0] ext_int_request,
  // second port levels to peripherals
  output logic timer1_capture,
  output logic timer1_count_clock,
  output logic rto_trigger,
  output logic timer2_capture_b,
  output logic timer2_ext_clock_in,
  output logic timer2_capture_compare_a,
  output logic timer0_capture,
  output logic timer0_count_clock,
  output logic uart_baud_clock_in,
  output logic serial1_clock_in,
  output logic converter_trigger,
  output logic serial0_data_in
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [PORT_W-1:0] p1_s1, p1_s2, p2_s1, p2_s2, p3_s1, p3_s2;
  logic [PORT_W-1:0] p2_prev;

  always_ff @(posedge clock) begin
    p1_s1 <= port1_pin_in;
    p1_s2 <= p1_s1;
    p2_s1 <= port2_pin_in;
    p2_s2 <= p2_s1;
    p3_s1 <= port3_pin_in;
    p3_s2 <= p3_s1;
    p2_prev <= p2_s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] port1_latch, port3_latch;
  logic [7:0] port1_direction_reg, port3_direction_reg;
  logic [7:0] port1_function_select, port3_function_select;
  logic [7:0] pullup_option_low;
  logic [7:0] port3_open_drain;
  logic [7:0] ext_int_edge_cfg0, ext_int_edge_cfg1;

  // latches take every write whatever the direction, as a later switch to output shows them
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port1_latch <= RST_LATCH;
      port3_latch <= RST_LATCH;
    end else if (reg_write) begin
      if (reg_addr == ADDR_PORT1_DATA) begin
        port1_latch <= reg_wdata;
      end
      if (reg_addr == ADDR_PORT3_DATA) begin
        port3_latch <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port1_direction_reg <= RST_DIR;
      port3_direction_reg <= RST_DIR;
      port1_function_select <= RST_FSEL;
      port3_function_select <= RST_FSEL;
    end else if (reg_write) begin
      if (reg_addr == ADDR_PORT1_DIR) begin
        port1_direction_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_PORT3_DIR) begin
        port3_direction_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_PORT1_FSEL) begin
        port1_function_select <= reg_wdata & PORT1_FSEL_MASK;
      end
      if (reg_addr == ADDR_PORT3_FSEL) begin
        port3_function_select <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pullup_option_low <= RST_PULLUP_OPTION_LOW;
      port3_open_drain <= RST_OPEN_DRAIN;
      ext_int_edge_cfg0 <= RST_EDGE_CFG;
      ext_int_edge_cfg1 <= RST_EDGE_CFG;
    end else if (reg_write) begin
      if (reg_addr == ADDR_PULLUP_OPTION_LOW) begin
        pullup_option_low <= reg_wdata & PULLUP_OPTION_MASK;
      end
      if (reg_addr == ADDR_PORT3_OPEN_DRAIN) begin
        port3_open_drain <= reg_wdata & OPEN_DRAIN_MASK;
      end
      if (reg_addr == ADDR_EXT_INT_EDGE_CFG0) begin
        ext_int_edge_cfg0 <= reg_wdata;
      end
      if (reg_addr == ADDR_EXT_INT_EDGE_CFG1) begin
        ext_int_edge_cfg1 <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control-mode signals from the peripherals

  logic [7:0] p1_ctrl_out, p1_ctrl_drv, p3_ctrl_out, p3_ctrl_drv;

  always_comb begin
    p1_ctrl_out = {3'h0, serial2_data_out, 1'b0, serial2_clock_out, 2'h0};
    p1_ctrl_drv = {3'h0, 1'b1, 1'b0, serial2_clock_drive, 2'h0};
    p3_ctrl_out = {timer_out, serial0_data_out, serial0_clock, serial1_data_out, 1'b0};
    p3_ctrl_drv = {4'hf, 1'b1, serial0_clock_drive, 1'b1, 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive and pull-ups

  logic [7:0] next_p1_out, next_p1_oe, next_p3_out, next_p3_oe, p3_val, p3_drv;

  always_comb begin
    // control mode drives irrespective of direction; port mode drives when direction is 0
    next_p1_out = (port1_function_select & p1_ctrl_out) | (~port1_function_select & port1_latch);
    next_p1_oe = (port1_function_select & p1_ctrl_drv) | (~port1_function_select & ~port1_direction_reg);
    p3_val = (port3_function_select & p3_ctrl_out) | (~port3_function_select & port3_latch);
    p3_drv = (port3_function_select & p3_ctrl_drv) | (~port3_function_select & ~port3_direction_reg);
    // open drain pulls low only and releases for a one
    next_p3_out = p3_val & ~port3_open_drain;
    next_p3_oe = p3_drv & ~(port3_open_drain & p3_val);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port1_pin_out <= 8'h00;
      port1_pin_oe <= 8'h00;
      port3_pin_out <= 8'h00;
      port3_pin_oe <= 8'h00;
      port1_pullup_on <= 8'h00;
      port2_pullup_on <= 8'h00;
      port3_pullup_on <= 8'h00;
    end else begin
      port1_pin_out <= next_p1_out;
      port1_pin_oe <= next_p1_oe;
      port3_pin_out <= next_p3_out;
      port3_pin_oe <= next_p3_oe;
      // direction alone gates the pull-up, control-mode outputs included
      port1_pullup_on <= {PORT_W{pullup_option_low[PU_PORT1_BIT]}} & port1_direction_reg;
      port2_pullup_on <= {PORT_W{pullup_option_low[PU_PORT2_BIT]}} & PORT2_PULLUP_LINES;
      port3_pullup_on <= {PORT_W{pullup_option_low[PU_PORT3_BIT]}} & port3_direction_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] p1_read, p3_read, next_rdata;

  always_comb begin
    // direction 1 shows the pin; direction 0 shows latch or the internal control signal
    p1_read = (port1_direction_reg & p1_s2)
            | (~port1_direction_reg & port1_function_select & p1_ctrl_out)
            | (~port1_direction_reg & ~port1_function_select & port1_latch);
    p3_read = (port3_direction_reg & p3_s2)
            | (~port3_direction_reg & port3_function_select & p3_ctrl_out)
            | (~port3_direction_reg & ~port3_function_select & port3_latch);
    unique case (reg_addr)
      ADDR_PORT1_DATA: next_rdata = p1_read;
      ADDR_PORT2_DATA: next_rdata = p2_s2;
      ADDR_PORT3_DATA: next_rdata = p3_read;
      ADDR_PORT1_DIR: next_rdata = port1_direction_reg;
      ADDR_PORT3_DIR: next_rdata = port3_direction_reg;
      ADDR_PORT1_FSEL: next_rdata = port1_function_select;
      ADDR_PORT3_FSEL: next_rdata = port3_function_select;
      ADDR_PULLUP_OPTION_LOW: next_rdata = pullup_option_low;
      ADDR_PORT3_OPEN_DRAIN: next_rdata = port3_open_drain;
      ADDR_EXT_INT_EDGE_CFG0: next_rdata = ext_int_edge_cfg0;
      ADDR_EXT_INT_EDGE_CFG1: next_rdata = ext_int_edge_cfg1;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the second port

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    unique case (ppc_edge_t'(sel))
      ppc_edge_fall: edge_hit = fall;
      ppc_edge_rise: edge_hit = rise;
      ppc_edge_both: edge_hit = rise | fall;
      ppc_edge_none: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  logic [11:0] edge_fields;
  logic [NUM_EXT_INT-1:0] next_ext_int;

  always_comb begin
    edge_fields = {ext_int_edge_cfg1[5:0], ext_int_edge_cfg0[6:1]};
    for (int i = 0; i < NUM_EXT_INT; i++) begin
      next_ext_int[i] = edge_hit(edge_fields[2*i +: 2], p2_s2[i+1], p2_prev[i+1]);
    end
  end

  // nmi has no mask anywhere in this path, so enable state never blocks it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nmi_request <= 1'b0;
      ext_int_request <= '0;
    end else begin
      nmi_request <= ext_int_edge_cfg0[NMI_EDGE_BIT] ? (p2_s2[0] & ~p2_prev[0])
                                                      : (~p2_s2[0] & p2_prev[0]);
      ext_int_request <= next_ext_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // levels to peripherals, always fed whatever the port settings

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer1_capture <= 1'b0;
      timer1_count_clock <= 1'b0;
      rto_trigger <= 1'b0;
      timer2_capture_b <= 1'b0;
      timer2_ext_clock_in <= 1'b0;
      timer2_capture_compare_a <= 1'b0;
      timer0_capture <= 1'b0;
      timer0_count_clock <= 1'b0;
      uart_baud_clock_in <= 1'b0;
      serial1_clock_in <= 1'b0;
      converter_trigger <= 1'b0;
      serial0_data_in <= 1'b0;
      serial2_clock_in <= 1'b0;
      serial2_data_in <= 1'b0;
      serial1_data_in <= 1'b0;
      serial0_clock_in <= 1'b0;
    end else begin
      timer1_capture <= p2_s2[1];
      timer1_count_clock <= p2_s2[1];
      rto_trigger <= p2_s2[1];
      timer2_capture_b <= p2_s2[2];
      timer2_ext_clock_in <= p2_s2[3];
      timer2_capture_compare_a <= p2_s2[3];
      timer0_capture <= p2_s2[4];
      timer0_count_clock <= p2_s2[4];
      uart_baud_clock_in <= p2_s2[5];
      serial1_clock_in <= p2_s2[5];
      converter_trigger <= p2_s2[6];
      serial0_data_in <= p2_s2[7];
      serial2_clock_in <= p1_s2[2];
      serial2_data_in <= p1_s2[3];
      serial1_data_in <= p3_s2[0];
      serial0_clock_in <= p3_s2[2];
    end
  end

endmodule : ppc_ports
`default_nettype wire

/* tb/ppc_props.sv */
// concurrent checks on the pins and register port of the port pin block
`default_nettype none
module ppc_props
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  // pins
  input wire logic [PORT_W-1:0] port1_pin_oe,
  input wire logic [PORT_W-1:0] port1_pullup_on,
  input wire logic [PORT_W-1:0] port2_pin_in,
  input wire logic [PORT_W-1:0] port2_pullup_on,
  input wire logic [PORT_W-1:0] port3_pin_oe,
  // second port towards peripherals
  input wire logic nmi_request,
  input wire logic [NUM_EXT_INT-1:0] ext_int_request,
  input wire logic converter_trigger,
  input wire logic serial0_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  a_reset_pins_off: assert property ($rose(rst_n) |->
    (port1_pin_oe | port3_pin_oe | port2_pullup_on) == 8'h00)
    else $error("pins driven right after reset");
  a_option_top_zero: assert property (reg_read && reg_addr == 16'hff4e |=> reg_rdata[7] == 1'b0)
    else $error("pull-up option bit 7 reads one");
  a_port2_readback: assert property (($stable(port2_pin_in) [*4] ##0
    (reg_read && reg_addr == ADDR_PORT2_DATA)) |=> reg_rdata == $past(port2_pin_in))
    else $error("second port read differs from pins");
  a_port2_group_pull: assert property (port2_pullup_on == 8'h00 || port2_pullup_on == 8'hfc)
    else $error("second port pull-ups not grouped");
  a_port2_feeds: assert property ($past(rst_n, 3) |->
    converter_trigger == $past(port2_pin_in[6], 3) && serial0_data_in == $past(port2_pin_in[7], 3))
    else $error("second port level not passed on");
  a_nmi_on_edge: assert property (nmi_request |-> $past(port2_pin_in[0], 3) != $past(port2_pin_in[0], 4))
    else $error("nmi pulse without pin edge");
  a_ext_int_edge: assert property ((ext_int_request
    & ~($past(port2_pin_in[6:1], 3) ^ $past(port2_pin_in[6:1], 4))) == 6'h00)
    else $error("interrupt pulse without pin edge");
  a_port1_pull_input: assert property ((port1_pullup_on & port1_pin_oe & 8'he3) == 8'h00)
    else $error("pull-up on a driven port pin");
  c_nmi: cover property (nmi_request);
  c_all_ints: cover property (ext_int_request == 6'h3f);
  c_group_pull: cover property (port2_pullup_on == 8'hfc);
endmodule : ppc_props
bind ppc_ports ppc_props ppc_props_inst (.clock, .rst_n, .reg_addr, .reg_read, .reg_rdata, .port1_pin_oe,
  .port1_pullup_on, .port2_pin_in, .port2_pullup_on, .port3_pin_oe, .nmi_request, .ext_int_request,
  .converter_trigger, .serial0_data_in);
`default_nettype wire

/* tb/ppc_pin_env.sv */
// outside circuitry on one 8-bit port: drivers, pull-ups, floating lines
`default_nettype none
module ppc_pin_env (
  // clock
  input wire logic clock,
  // block side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  // outside drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drift = 8'h00;
  // an undriven line without pull-up wanders, so a stale level never passes
  always @(posedge clock) drift <= ~drift;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pullup_on | drift));
endmodule : ppc_pin_env
`default_nettype wire

/* tb/ppc_ports_tb_top.sv */
// self-checking bench of the port pin block
`default_nettype none
module ppc_ports_tb_top
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup_on, port2_pin_in, port2_pullup_on;
  logic [7:0] port3_pin_in, port3_pin_out, port3_pin_oe, port3_pullup_on;
  logic [7:0] x1_val = 8'h00, x2_val = 8'h00, x3_val = 8'h00, x1_en = 8'hff, x2_en = 8'hff, x3_en = 8'hff;
  logic serial2_clock_out = 1'b0, serial2_clock_drive = 1'b0, serial2_data_out = 1'b0, serial1_data_out = 1'b0;
  logic serial0_clock = 1'b0, serial0_clock_drive = 1'b0, serial0_data_out = 1'b0;
  logic [3:0] timer_out = 4'h0;
  logic serial2_clock_in, serial2_data_in, serial1_data_in, serial0_clock_in, nmi_request;
  logic [5:0] ext_int_request;
  logic timer1_capture, timer1_count_clock, rto_trigger, timer2_capture_b, timer2_ext_clock_in;
  logic timer2_capture_compare_a, timer0_capture, timer0_count_clock, uart_baud_clock_in, serial1_clock_in;
  logic converter_trigger, serial0_data_in;
  logic [31:0] seed = 32'h0001_758b;
  logic [7:0] d1, d3, l3, lv;
  int bad_count = 0, compares = 0, cyc = 0, nmi_n = 0, int_n = 0;
  localparam logic [15:0] RADDR [9] = '{ADDR_PORT1_DIR, ADDR_PORT3_DIR, ADDR_PORT1_FSEL, ADDR_PORT3_FSEL,
    ADDR_PULLUP_OPTION_LOW, ADDR_PORT3_OPEN_DRAIN, ADDR_EXT_INT_EDGE_CFG0, ADDR_EXT_INT_EDGE_CFG1, 16'hff7f};
  ////////////////////////////////////////////////////////////
  ppc_ports ppc_ports_inst (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_pullup_on, .port2_pin_in, .port2_pullup_on,
    .port3_pin_in, .port3_pin_out, .port3_pin_oe, .port3_pullup_on, .serial2_clock_out, .serial2_clock_drive,
    .serial2_data_out, .serial2_clock_in, .serial2_data_in, .serial1_data_out, .serial0_clock,
    .serial0_clock_drive, .serial0_data_out, .timer_out, .serial1_data_in, .serial0_clock_in, .nmi_request,
    .ext_int_request, .timer1_capture, .timer1_count_clock, .rto_trigger, .timer2_capture_b,
    .timer2_ext_clock_in, .timer2_capture_compare_a, .timer0_capture, .timer0_count_clock,
    .uart_baud_clock_in, .serial1_clock_in, .converter_trigger, .serial0_data_in);
  ppc_pin_env env1 (.clock, .pin_out(port1_pin_out), .pin_oe(port1_pin_oe), .pullup_on(port1_pullup_on),
    .ext_val(x1_val), .ext_en(x1_en), .pin_lvl(port1_pin_in));
  ppc_pin_env env2 (.clock, .pin_out(8'h00), .pin_oe(8'h00), .pullup_on(port2_pullup_on),
    .ext_val(x2_val), .ext_en(x2_en), .pin_lvl(port2_pin_in));
  ppc_pin_env env3 (.clock, .pin_out(port3_pin_out), .pin_oe(port3_pin_oe), .pullup_on(port3_pullup_on),
    .ext_val(x3_val), .ext_en(x3_en), .pin_lvl(port3_pin_in));
  ////////////////////////////////////////////////////////////
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    nmi_n <= nmi_n + nmi_request;
    int_n <= int_n + $countones(ext_int_request);
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // one pulse per active edge on each of six lines; one rise and one fall are sent
  function automatic logic [7:0] exp_pulses(input logic [1:0] code);
    return code == 2'h3 ? 8'h00 : code == 2'h2 ? 8'h0c : 8'h06;
  endfunction : exp_pulses
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    settle(1);
    chk(port1_pin_oe | port3_pin_oe, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rd_chk(RADDR[i], i < 2 ? 8'hff : 8'h00);
    end
    wr(ADDR_PULLUP_OPTION_LOW, 8'h04);
    x2_en <= 8'h03;
    settle(4);
    chk(port2_pullup_on, 8'hfc);
    rd_chk(ADDR_PORT2_DATA, {6'h3f, x2_val[1:0]});
    @(posedge clock);
    x2_en <= 8'hff;
    wr(ADDR_PULLUP_OPTION_LOW, 8'hff);
    rd_chk(ADDR_PULLUP_OPTION_LOW, 8'h7f);
    wr(ADDR_PULLUP_OPTION_LOW, 8'h0a);
    settle(2);
    chk(port2_pullup_on, 8'h00);
    for (int n = 0; n < 20; n++) begin
      d1 = rnd();
      d3 = rnd();
      l3 = rnd();
      wr(ADDR_PORT1_DIR, d1);
      wr(ADDR_PORT3_DIR, d3);
      wr(ADDR_PORT3_DATA, l3);
      x1_val <= rnd();
      x2_val <= rnd();
      x3_val <= rnd();
      x1_en <= d1;
      x3_en <= d3;
      settle(4);
      chk(port1_pullup_on, d1);
      chk(port3_pullup_on, d3);
      chk(port3_pin_oe, ~d3);
      chk(port3_pin_out & ~d3, l3 & ~d3);
      lv = {timer1_capture, timer1_count_clock, rto_trigger, timer2_capture_b, timer2_ext_clock_in,
        timer2_capture_compare_a, timer0_capture, timer0_count_clock};
      chk(lv, {{3{x2_val[1]}}, x2_val[2], {2{x2_val[3]}}, {2{x2_val[4]}}});
      lv = {4'h0, uart_baud_clock_in, serial1_clock_in, converter_trigger, serial0_data_in};
      chk(lv, {4'h0, x2_val[5], x2_val[5], x2_val[6], x2_val[7]});
      lv = (x3_val & d3) | (l3 & ~d3);
      chk({6'h00, serial0_clock_in, serial1_data_in}, {6'h00, lv[2], lv[0]});
      rd_chk(ADDR_PORT3_DATA, (x3_val & d3) | (l3 & ~d3));
      rd_chk(ADDR_PORT1_DATA, x1_val & d1);
      rd_chk(ADDR_PORT2_DATA, x2_val);
    end
    wr(ADDR_PORT1_FSEL, 8'h1c);
    wr(ADDR_PORT1_DIR, 8'hff);
    serial2_clock_out <= 1'b1;
    x1_en <= 8'hff;
    x1_val <= 8'h08;
    settle(4);
    rd_chk(ADDR_PORT1_DATA, 8'h08);
    chk(port1_pullup_on, 8'hff);
    chk({6'h00, serial2_data_in, serial2_clock_in}, 8'h02);
    wr(ADDR_PORT1_DIR, 8'h00);
    settle(2);
    rd_chk(ADDR_PORT1_DATA, 8'h04);
    chk(port1_pullup_on, 8'h00);
    l3 = rnd();
    @(posedge clock);
    timer_out <= l3[3:0];
    serial0_clock_drive <= 1'b1;
    serial0_clock <= 1'b1;
    wr(ADDR_PORT3_OPEN_DRAIN, 8'h0c);
    wr(ADDR_PORT3_FSEL, 8'hfc);
    settle(2);
    chk(port3_pin_oe & 8'hfc, 8'hf8);
    chk(port3_pin_out & 8'hfc, {l3[3:0], 4'h0});
    // direction 0 in control mode shows the internal signals, port-mode bits the latch
    wr(ADDR_PORT3_DIR, 8'h00);
    wr(ADDR_PORT3_DATA, 8'h00);
    settle(2);
    rd_chk(ADDR_PORT3_DATA, {l3[3:0], 4'h4});
    @(posedge clock);
    x2_val <= 8'h00;
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_EXT_INT_EDGE_CFG0, {1'b0, e[1:0], e[1:0], e[1:0], e[0]});
      wr(ADDR_EXT_INT_EDGE_CFG1, {2'b00, e[1:0], e[1:0], e[1:0]});
      settle(6);
      d1 = nmi_n[7:0];
      d3 = int_n[7:0];
      @(posedge clock);
      x2_val <= 8'h7f;
      settle(6);
      @(posedge clock);
      x2_val <= 8'h00;
      settle(6);
      chk(nmi_n[7:0] - d1, 8'h01);
      chk(int_n[7:0] - d3, exp_pulses(e[1:0]));
    end
    stop_test();
  end
endmodule : ppc_ports_tb_top
`default_nettype wire
